//--- pkg/sdc_pkg.sv
// package: constants, types and register map of the chained dma engine
package sdc_pkg;
  // ==================================================
  // sizes
  localparam int NCH = 16;
  localparam int REQ_N = 32;
  localparam int CMD_WORDS = 5;
  localparam int BUF_DEPTH = 32;
  localparam logic [7:0] BUF_BYTES = 8'h40;
  // ==================================================
  // register map, byte addresses
  localparam logic [8:0] REG_IRQ_STAT = 9'h000;
  localparam logic [8:0] REG_IRQ_EN = 9'h004;
  localparam logic [8:0] REG_IRQ_CLR = 9'h008;
  localparam logic [8:0] REG_TMO = 9'h00C;
  localparam int CH_SPACE_BIT = 8;
  localparam logic [1:0] CH_CMD = 2'h0;
  localparam logic [1:0] CH_SEMA = 2'h1;
  localparam logic [1:0] CH_CFG = 2'h2;
  localparam logic [1:0] CH_STAT = 2'h3;
  // ==================================================
  // channel config fields
  localparam int CFG_SEL = 0;
  localparam int CFG_TRIG = 5;
  localparam int CFG_GAP = 8;
  // command word order and control word fields
  localparam logic [2:0] CW_NEXT = 3'h0;
  localparam logic [2:0] CW_SRC = 3'h1;
  localparam logic [2:0] CW_DST = 3'h2;
  localparam logic [2:0] CW_CTL = 3'h3;
  localparam logic [2:0] CW_STRIDE = 3'h4;
  localparam int CTL_CNT = 0;
  localparam int CTL_BLEN = 16;
  localparam int CTL_WID = 21;
  localparam int CTL_STYP = 23;
  localparam int CTL_DTYP = 25;
  localparam int CTL_SSTP = 27;
  localparam int CTL_DSTP = 29;
  localparam int CTL_DEC = 31;
  // ==================================================
  // reset values
  localparam logic [15:0] TMO_RST = 16'h0100;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [31:0] IEN_RST = 32'h0000_0000;
  // ==================================================
  // enumerations
  typedef enum logic [1:0] {ERR_NONE = 2'h0, ERR_TMO = 2'h1, ERR_OVF = 2'h2,
                            ERR_BUS = 2'h3} sdc_err_t;
  typedef enum logic [1:0] {EP_LIN = 2'h0, EP_2D = 2'h1, EP_FIFO = 2'h2} sdc_kind_t;
  typedef enum logic [1:0] {ST_INC = 2'h0, ST_DEC = 2'h1, ST_FIX = 2'h2} sdc_step_t;
  typedef enum logic [1:0] {W8 = 2'h0, W16 = 2'h1, W32 = 2'h2} sdc_wid_t;
  typedef enum logic [5:0] {S_IDLE = 6'h01, S_FETCH = 6'h02, S_WAIT = 6'h04,
                            S_READ = 6'h08, S_WRITE = 6'h10, S_NEXT = 6'h20} sdc_state_t;
  // ==================================================
  // memory master port
  typedef struct packed {
    logic valid;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sdc_mreq_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } sdc_mrsp_t;
endpackage

//--- rtl/sdc_rr_arb.sv
// round-robin picker of the next channel to serve
`timescale 1ns/1ps
module sdc_rr_arb #(
  parameter int N = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] req_i,
  input wire logic take_i,
  output logic [$clog2(N)-1:0] gnt_o,
  output logic valid_o
);
  import sdc_pkg::*;
  localparam int W = $clog2(N);
  logic [W-1:0] last_q; // last channel served

  // ==================================================
  // search upward from the one after the last grant
  always_comb begin
    logic [W-1:0] idx;
    idx = '0;
    gnt_o = '0;
    valid_o = 1'b0;
    for (int i = N; i >= 1; i--) begin
      idx = last_q + W'(i);
      if (req_i[idx]) begin
        gnt_o = idx;
        valid_o = 1'b1;
      end
    end
  end

  // remember the grant once the engine takes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= '1;
    end else if (take_i && valid_o) begin
      last_q <= gnt_o;
    end
  end
endmodule

//--- rtl/sdc_dma.sv
// chained dma engine: wishbone registers, command fetch and burst mover
`timescale 1ns/1ps
module sdc_dma (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [sdc_pkg::REQ_N-1:0] dma_req_i,
  output sdc_pkg::sdc_mreq_t mem_req_o,
  input wire sdc_pkg::sdc_mrsp_t mem_rsp_i,
  output logic irq_o
);
  import sdc_pkg::*;

  // ==================================================
  // helpers
  function automatic logic [7:0] wbytes(input logic [1:0] w);
    unique case (w)
      W8: wbytes = 8'h01;
      W16: wbytes = 8'h02;
      default: wbytes = 8'h04;
    endcase
  endfunction

  // next address for one endpoint
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] kind,
                                            input logic [1:0] st, input logic [1:0] w);
    logic [31:0] b;
    b = {24'h0, wbytes(w)};
    if (kind == EP_FIFO || st == ST_FIX) begin
      step_addr = a;
    end else if (st == ST_DEC) begin
      step_addr = a - b;
    end else begin
      step_addr = a + b;
    end
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // ==================================================
  // channel registers
  logic [31:0] cmd_q [NCH]; // command pointer, 0 means none
  logic [7:0] sema_q [NCH]; // semaphore count
  logic [15:0] cfg_q [NCH]; // trigger select and gap
  sdc_err_t err_q [NCH]; // last error kind
  logic [7:0] gap_q [NCH]; // idle cycles left before next burst
  // global registers
  logic [15:0] done_sts_q; // sticky completion bits
  logic [15:0] err_sts_q; // sticky error bits
  logic [31:0] ien_q; // interrupt enables
  logic [15:0] tmo_lim_q; // burst time-out limit, 0 disables

  // bus slave
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic wr_fire; // write takes effect this edge
  logic ch_hit; // access in channel space
  logic [3:0] ch_sel;
  logic [1:0] ch_reg;

  // engine
  sdc_state_t state_q;
  logic [3:0] ch_q; // active channel
  logic [2:0] fidx_q; // command word being fetched
  logic [31:0] nxt_q, src_q, dst_q, ctl_q, strd_q;
  logic [15:0] rem_q; // beats left in command
  logic [5:0] blen_q; // beats in this burst
  logic [5:0] bcnt_q; // beat index in burst
  logic [7:0] fill_q; // bytes held in buffer
  logic [15:0] tmo_q; // cycles spent in burst
  logic [31:0] buf_q [BUF_DEPTH]; // burst buffer

  // combinational
  logic [NCH-1:0] can_run; // channel has work
  logic [NCH-1:0] go; // channel may start a burst
  logic arb_v;
  logic [3:0] arb_g;
  logic [1:0] wid;
  logic [7:0] fill_nx;
  logic [5:0] blen_cmd;
  logic beat_ok; // beat acknowledged without error
  logic last_beat;
  logic abort;
  sdc_err_t abort_kind;
  logic burst_end; // last write beat of a burst
  logic next_ev; // command finished this cycle
  logic dec_ev; // semaphore drops this cycle

  // ==================================================
  // wishbone slave
  assign ch_hit = wb_adr_i[CH_SPACE_BIT];
  assign ch_sel = wb_adr_i[7:4];
  assign ch_reg = wb_adr_i[3:2];
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // read data mux, unmapped reads zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (ch_hit) begin
      unique case (ch_reg)
        CH_CMD: rd_d = cmd_q[ch_sel];
        CH_SEMA: rd_d = {24'h0, sema_q[ch_sel]};
        CH_CFG: rd_d = {16'h0, cfg_q[ch_sel]};
        CH_STAT: rd_d = {27'h0, (state_q != S_IDLE) && (ch_q == ch_sel), 2'h0,
                         err_q[ch_sel]};
      endcase
    end else begin
      unique case (wb_adr_i)
        REG_IRQ_STAT: rd_d = {err_sts_q, done_sts_q};
        REG_IRQ_EN: rd_d = ien_q;
        REG_TMO: rd_d = {16'h0, tmo_lim_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // ack one cycle after request, data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      dat_q <= rd_d;
    end
  end

  // ==================================================
  // global registers and interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_q <= IEN_RST;
      tmo_lim_q <= TMO_RST;
    end else if (wr_fire && !ch_hit) begin
      if (wb_adr_i == REG_IRQ_EN) begin
        ien_q <= be_merge(ien_q, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == REG_TMO) begin
        tmo_lim_q <= 16'(be_merge({16'h0, tmo_lim_q}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // sticky status, a new event wins over a clear
  always_ff @(posedge clk_i) begin
    logic [31:0] clr;
    logic [31:0] set;
    clr = 32'h0000_0000;
    set = 32'h0000_0000;
    if (wr_fire && !ch_hit && wb_adr_i == REG_IRQ_CLR) begin
      clr = be_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    end
    if (next_ev) begin
      set[ch_q] = 1'b1;
    end
    if (abort) begin
      set[16 + 32'(ch_q)] = 1'b1;
    end
    if (rst_i) begin
      done_sts_q <= 16'h0000;
      err_sts_q <= 16'h0000;
    end else begin
      {err_sts_q, done_sts_q} <= ({err_sts_q, done_sts_q} & ~clr) | set;
    end
  end

  assign irq_o = |({err_sts_q, done_sts_q} & ien_q);

  // ==================================================
  // per-channel state
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      logic sw;
      logic mine;
      sw = wr_fire && ch_hit && ch_sel == 4'(c);
      mine = ch_q == 4'(c);
      if (rst_i) begin
        cmd_q[c] <= 32'h0000_0000;
        sema_q[c] <= 8'h00;
        cfg_q[c] <= CFG_RST;
        err_q[c] <= ERR_NONE;
        gap_q[c] <= 8'h00;
      end else begin
        // pointer follows the chain, 0 ends it
        if (sw && ch_reg == CH_CMD) begin
          cmd_q[c] <= be_merge(cmd_q[c], wb_dat_i, wb_sel_i);
        end else if (next_ev && mine) begin
          cmd_q[c] <= nxt_q;
        end
        // software load, else count down per flagged command
        if (sw && ch_reg == CH_SEMA && wb_sel_i[0]) begin
          sema_q[c] <= wb_dat_i[7:0];
        end else if (dec_ev && mine) begin
          sema_q[c] <= sema_q[c] - 8'h01;
        end
        if (sw && ch_reg == CH_CFG) begin
          cfg_q[c] <= 16'(be_merge({16'h0, cfg_q[c]}, wb_dat_i, wb_sel_i));
        end
        // error held until semaphore rewritten, a new error wins
        if (abort && mine) begin
          err_q[c] <= abort_kind;
        end else if (sw && ch_reg == CH_SEMA) begin
          err_q[c] <= ERR_NONE;
        end
        // bus usage gap after each untriggered burst
        if (burst_end && mine && !cfg_q[c][CFG_TRIG]) begin
          gap_q[c] <= cfg_q[c][CFG_GAP +: 8];
        end else if (gap_q[c] != 8'h00) begin
          gap_q[c] <= gap_q[c] - 8'h01;
        end
      end
    end
  end

  // channel readiness
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      can_run[c] = sema_q[c] != 8'h00 && cmd_q[c] != 32'h0 && err_q[c] == ERR_NONE;
      go[c] = cfg_q[c][CFG_TRIG] ? dma_req_i[cfg_q[c][CFG_SEL +: 5]]
                                 : gap_q[c] == 8'h00;
    end
  end

  sdc_rr_arb #(.N(NCH)) u_arb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(can_run),
    .take_i(state_q == S_IDLE),
    .gnt_o(arb_g),
    .valid_o(arb_v)
  );

  // ==================================================
  // burst checks
  assign wid = ctl_q[CTL_WID +: 2];
  assign fill_nx = fill_q + wbytes(wid);
  assign blen_cmd = (ctl_q[CTL_BLEN +: 5] == 5'h00) ? 6'h01 : {1'b0, ctl_q[CTL_BLEN +: 5]};
  assign beat_ok = mem_rsp_i.ack && !mem_rsp_i.err;
  assign last_beat = bcnt_q + 6'h01 == blen_q;
  assign burst_end = state_q == S_WRITE && beat_ok && last_beat && !abort;
  assign next_ev = state_q == S_NEXT;
  assign dec_ev = next_ev && ctl_q[CTL_DEC] && sema_q[ch_q] != 8'h00;

  // error priority: bus error, overflow, time-out
  always_comb begin
    abort = 1'b0;
    abort_kind = ERR_NONE;
    if ((state_q == S_FETCH || state_q == S_READ || state_q == S_WRITE) && mem_rsp_i.err) begin
      abort = 1'b1;
      abort_kind = ERR_BUS;
    end else if (state_q == S_READ && mem_rsp_i.ack && fill_nx > BUF_BYTES) begin
      abort = 1'b1;
      abort_kind = ERR_OVF;
    end else if ((state_q == S_READ || state_q == S_WRITE) && tmo_lim_q != 16'h0
                 && tmo_q >= tmo_lim_q) begin
      abort = 1'b1;
      abort_kind = ERR_TMO;
    end
  end

  // ==================================================
  // memory port
  always_comb begin
    mem_req_o = '0;
    unique case (state_q)
      S_FETCH: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.size = W32;
        mem_req_o.addr = cmd_q[ch_q] + {27'h0, fidx_q, 2'h0};
      end
      S_READ: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.size = wid;
        mem_req_o.addr = src_q;
      end
      S_WRITE: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.we = 1'b1;
        mem_req_o.size = wid;
        mem_req_o.addr = dst_q;
        mem_req_o.wdata = buf_q[bcnt_q[4:0]];
      end
      default: mem_req_o = '0;
    endcase
  end

  // buffer fill on read beats
  always_ff @(posedge clk_i) begin
    if (state_q == S_READ && beat_ok && !abort) begin
      buf_q[bcnt_q[4:0]] <= mem_rsp_i.rdata;
    end
  end

  // ==================================================
  // engine sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      ch_q <= 4'h0;
      fidx_q <= 3'h0;
      nxt_q <= 32'h0;
      src_q <= 32'h0;
      dst_q <= 32'h0;
      ctl_q <= 32'h0;
      strd_q <= 32'h0;
      rem_q <= 16'h0;
      blen_q <= 6'h0;
      bcnt_q <= 6'h0;
      fill_q <= 8'h0;
      tmo_q <= 16'h0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (arb_v) begin
            ch_q <= arb_g;
            fidx_q <= 3'h0;
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (abort) begin
            state_q <= S_IDLE;
          end else if (mem_rsp_i.ack) begin
            unique case (fidx_q)
              CW_NEXT: nxt_q <= mem_rsp_i.rdata;
              CW_SRC: src_q <= mem_rsp_i.rdata;
              CW_DST: dst_q <= mem_rsp_i.rdata;
              CW_CTL: ctl_q <= mem_rsp_i.rdata;
              default: strd_q <= mem_rsp_i.rdata;
            endcase
            if (fidx_q == CW_CTL) begin
              rem_q <= mem_rsp_i.rdata[CTL_CNT +: 16];
            end
            fidx_q <= fidx_q + 3'h1;
            if (fidx_q == CW_STRIDE) begin
              state_q <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (sema_q[ch_q] == 8'h00) begin
            state_q <= S_IDLE;
          end else if (rem_q == 16'h0) begin
            state_q <= S_NEXT;
          end else if (go[ch_q]) begin
            blen_q <= ({10'h0, blen_cmd} < rem_q) ? blen_cmd : rem_q[5:0];
            bcnt_q <= 6'h0;
            fill_q <= 8'h0;
            tmo_q <= 16'h0;
            state_q <= S_READ;
          end
        end
        S_READ: begin
          tmo_q <= tmo_q + 16'h1;
          if (abort) begin
            state_q <= S_IDLE;
          end else if (beat_ok) begin
            fill_q <= fill_nx;
            src_q <= step_addr(src_q, ctl_q[CTL_STYP +: 2], ctl_q[CTL_SSTP +: 2], wid);
            bcnt_q <= last_beat ? 6'h0 : bcnt_q + 6'h01;
            if (last_beat) begin
              state_q <= S_WRITE;
            end
          end
        end
        S_WRITE: begin
          tmo_q <= tmo_q + 16'h1;
          if (abort) begin
            state_q <= S_IDLE;
          end else if (beat_ok) begin
            dst_q <= step_addr(dst_q, ctl_q[CTL_DTYP +: 2], ctl_q[CTL_DSTP +: 2], wid);
            bcnt_q <= bcnt_q + 6'h01;
            rem_q <= rem_q - 16'h1;
            if (last_beat) begin
              // 2d endpoints skip the row stride
              if (ctl_q[CTL_STYP +: 2] == EP_2D) begin
                src_q <= src_q + strd_q;
              end
              if (ctl_q[CTL_DTYP +: 2] == EP_2D) begin
                dst_q <= step_addr(dst_q, EP_LIN, ctl_q[CTL_DSTP +: 2], wid) + strd_q;
              end
              state_q <= (rem_q == 16'h1) ? S_NEXT : S_WAIT;
            end
          end
        end
        S_NEXT: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

//--- tb/sdc_dma_props.sv
// assertion checker for the chained dma engine ports
`timescale 1ns/1ps
module sdc_dma_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire sdc_pkg::sdc_mreq_t mem_req_o,
  input wire sdc_pkg::sdc_mrsp_t mem_rsp_i,
  input wire logic irq_o
);
  import sdc_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  // ==================================================
  // handshake steps
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_beat_wait;
    mem_req_o.valid && !mem_rsp_i.ack && !mem_rsp_i.err ##1 mem_req_o.valid;
  endsequence
  // ==================================================
  // register bus
  AST_ACK_ONE: assert property (disable iff (rst_i) s_req |=> s_ack)
    else $error("bus request not acked once");
  AST_ACK_CAUSE: assert property (disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_ACK_SINGLE: assert property (disable iff (rst_i) wb_ack_o |-> $rose(wb_ack_o))
    else $error("ack longer than one cycle");
  AST_ZERO_READ: assert property (disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
    && (wb_adr_i == REG_IRQ_CLR || wb_adr_i == 9'h010) |=> wb_dat_o == 32'h0)
    else $error("clear or unmapped read not zero");
  AST_RST_QUIET: assert property (rst_i |=> !wb_ack_o && !irq_o
    && wb_dat_o == 32'h0 && mem_req_o == '0)
    else $error("outputs active after reset");
  // ==================================================
  // memory master
  AST_BEAT_HOLD: assert property (disable iff (rst_i) s_beat_wait |->
    $stable(mem_req_o.addr) && $stable(mem_req_o.wdata) && $stable(mem_req_o.we))
    else $error("beat changed before answer");
  AST_ERR_STOP: assert property (disable iff (rst_i) mem_rsp_i.err |=> !mem_req_o.valid)
    else $error("request continues after bus error");
  AST_SIZE_OK: assert property (disable iff (rst_i)
    mem_req_o.valid |-> mem_req_o.size != 2'h3)
    else $error("illegal beat size");
endmodule
bind sdc_dma sdc_dma_props i_sdc_dma_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
  .mem_rsp_i(mem_rsp_i), .irq_o(irq_o));

//--- tb/sdc_mem_model.sv
// memory side model answering the engine's master port
`timescale 1ns/1ps
module sdc_mem_model (
  input wire logic clk_i,
  input wire sdc_pkg::sdc_mreq_t req_i,
  input wire logic [3:0] lat_i,
  input wire logic [31:0] err_addr_i,
  output sdc_pkg::sdc_mrsp_t rsp_o
);
  import sdc_pkg::*;
  logic [31:0] mem [256]; // word store
  logic [3:0] wait_q; // cycles waited on this beat
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'h0;
    end
    wait_q = 4'h0;
    rsp_o = '0;
  end
  // ==================================================
  // one answer pulse per beat, slow when asked
  always @(posedge clk_i) begin
    rsp_o.ack <= 1'h0;
    rsp_o.err <= 1'h0;
    if (req_i.valid && !rsp_o.ack && !rsp_o.err) begin
      if (wait_q < lat_i) begin
        wait_q <= wait_q + 4'h1;
        rsp_o.rdata <= ~rsp_o.rdata;
      end else if (req_i.addr == err_addr_i) begin
        wait_q <= 4'h0;
        rsp_o.err <= 1'h1; // commanded fault
      end else begin
        wait_q <= 4'h0;
        rsp_o.ack <= 1'h1;
        if (req_i.we) begin
          mem[req_i.addr[9:2]] <= req_i.wdata;
        end else begin
          rsp_o.rdata <= mem[req_i.addr[9:2]];
        end
      end
    end else begin
      wait_q <= 4'h0; // abandoned beat restarts the wait
      rsp_o.rdata <= ~rsp_o.rdata; // no stale data between beats
    end
  end
endmodule

//--- tb/test_semaphore_chained_dma_channels.sv
// self-checking bench for the chained dma engine
`timescale 1ns/1ps
module test_semaphore_chained_dma_channels;
  import sdc_pkg::*;
  // ==================================================
  // connections
  localparam logic RD = 1'h0;
  localparam logic WR = 1'h1;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [8:0] wb_adr_i;
  logic [3:0] wb_sel_i, lat;
  logic [31:0] wb_dat_i, wb_dat_o, rd, err_addr;
  logic [REQ_N-1:0] dma_req_i;
  sdc_mreq_t mem_req_o;
  sdc_mrsp_t mem_rsp_i;
  int err_count, comparisons;
  sdc_dma i_sdc_dma (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_req_i(dma_req_i),
    .mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i), .irq_o(irq_o));
  sdc_mem_model i_sdc_mem_model (.clk_i(clk_i), .req_i(mem_req_o), .lat_i(lat),
    .err_addr_i(err_addr), .rsp_o(mem_rsp_i));
  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end
  // ==================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb_acc(input logic we, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    @(posedge clk_i);
  endtask
  function automatic logic [8:0] ca(input logic [3:0] c, input logic [1:0] r);
    return {1'h1, c, r, 2'h0};
  endfunction
  function automatic logic [31:0] ctl(input logic dec, input logic [1:0] dstp,
    input logic [1:0] sstp, input logic [4:0] bl, input logic [15:0] n);
    return {dec, dstp, sstp, EP_LIN, EP_LIN, W32, bl, n};
  endfunction
  function automatic logic [31:0] at(input logic [31:0] a);
    return i_sdc_mem_model.mem[a[9:2]];
  endfunction
  task automatic cmd(input logic [31:0] a, input logic [31:0] nx, input logic [31:0] s,
    input logic [31:0] d, input logic [31:0] c);
    i_sdc_mem_model.mem[a[9:2]] = nx;
    i_sdc_mem_model.mem[a[9:2] + 8'h1] = s;
    i_sdc_mem_model.mem[a[9:2] + 8'h2] = d;
    i_sdc_mem_model.mem[a[9:2] + 8'h3] = c;
    i_sdc_mem_model.mem[a[9:2] + 8'h4] = 32'h0;
  endtask
  task automatic start(input logic [3:0] c, input logic [31:0] a, input logic [31:0] cfg,
    input logic [31:0] sem);
    wb_acc(WR, ca(c, CH_CMD), a);
    wb_acc(WR, ca(c, CH_CFG), cfg);
    wb_acc(WR, ca(c, CH_SEMA), sem);
  endtask
  // two quiet polls in a row, the engine idles one cycle between commands
  task automatic idle(input logic [3:0] c);
    int quiet;
    quiet = 0;
    for (int i = 0; i < 400 && quiet < 2; i++) begin
      wb_acc(RD, ca(c, CH_STAT), 32'h0);
      quiet = (rd[4] === 1'h0) ? quiet + 1 : 0;
    end
    chk(32'(quiet), 32'h2);
  endtask
  // ==================================================
  // scenarios
  task automatic t_regs;
    wb_acc(RD, REG_IRQ_EN, 32'h0);
    chk(rd, IEN_RST);
    wb_acc(RD, REG_TMO, 32'h0);
    chk(rd, {16'h0, TMO_RST});
    wb_acc(RD, ca(4'h3, CH_CFG), 32'h0);
    chk(rd, {16'h0, CFG_RST});
    wb_acc(WR, ca(4'h3, CH_SEMA), 32'hFF);
    wb_acc(RD, ca(4'h3, CH_SEMA), 32'h0);
    chk(rd, 32'hFF);
    wb_acc(WR, 9'h010, 32'hFFFF_FFFF);
    wb_acc(RD, 9'h010, 32'h0);
    chk(rd, 32'h0);
    wb_acc(RD, REG_IRQ_CLR, 32'h0);
    chk(rd, 32'h0);
    wb_acc(WR, REG_IRQ_EN, 32'h0000_0008);
  endtask
  task automatic t_chain;
    i_sdc_mem_model.mem[8'h80] = 32'hA0A0_0001;
    i_sdc_mem_model.mem[8'h81] = 32'hA0A0_0002;
    i_sdc_mem_model.mem[8'h90] = 32'hB0B0_0003;
    cmd(32'h040, 32'h080, 32'h200, 32'h300, ctl(1'h1, ST_INC, ST_INC, 5'h00, 16'h0002));
    cmd(32'h080, 32'h0, 32'h240, 32'h380, ctl(1'h0, ST_DEC, ST_FIX, 5'h00, 16'h0002));
    start(4'h3, 32'h040, 32'h0, 32'h2);
    idle(4'h3);
    chk(at(32'h304), 32'hA0A0_0002);
    chk(at(32'h37C), 32'hB0B0_0003);
    chk(at(32'h380), 32'hB0B0_0003);
    wb_acc(RD, ca(4'h3, CH_SEMA), 32'h0);
    chk(rd, 32'h1);
    wb_acc(RD, ca(4'h3, CH_CMD), 32'h0);
    chk(rd, 32'h0);
    wb_acc(RD, REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h8);
    chk({31'h0, irq_o}, 32'h1);
    wb_acc(WR, REG_IRQ_CLR, 32'h8);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_trig;
    cmd(32'h0C0, 32'h0, 32'h204, 32'h320, ctl(1'h1, ST_INC, ST_INC, 5'h00, 16'h0001));
    start(4'h5, 32'h0C0, 32'h27, 32'h1);
    repeat (60) @(posedge clk_i);
    chk(at(32'h320), 32'h0);
    dma_req_i <= 32'h0000_0080;
    idle(4'h5);
    dma_req_i <= '0;
    chk(at(32'h320), 32'hA0A0_0002);
    wb_acc(RD, ca(4'h5, CH_SEMA), 32'h0);
    chk(rd, 32'h0);
    wb_acc(WR, REG_IRQ_CLR, 32'hFFFF_FFFF);
  endtask
  task automatic t_fault(input logic [3:0] c, input logic [31:0] a, input logic [31:0] k,
    input logic [31:0] code);
    cmd(a, 32'h0, 32'h200, 32'h340, k);
    start(c, a, 32'h0, 32'h3);
    idle(c);
    wb_acc(RD, ca(c, CH_STAT), 32'h0);
    chk(rd, code);
    wb_acc(RD, ca(c, CH_SEMA), 32'h0);
    chk(rd, 32'h3);
    wb_acc(RD, REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0001_0000 << c);
    chk({31'h0, irq_o}, 32'h1);
    wb_acc(WR, REG_IRQ_CLR, 32'hFFFF_FFFF);
  endtask
  // ==================================================
  // 2d destination, two-beat bursts, gap between untriggered bursts
  task automatic t_2d;
    i_sdc_mem_model.mem[8'h83] = 32'hC0C0_0004;
    cmd(32'h1C0, 32'h0, 32'h200, 32'h3C0,
      ctl(1'h1, ST_INC, ST_INC, 5'h02, 16'h0004) | (32'(EP_2D) << CTL_DTYP));
    i_sdc_mem_model.mem[8'h74] = 32'h10;
    start(4'hF, 32'h1C0, 32'h4000, 32'h1);
    repeat (40) @(posedge clk_i);
    chk(at(32'h3C4), 32'hA0A0_0002);
    chk(at(32'h3DC), 32'h0);
    idle(4'hF);
    chk(at(32'h3C8), 32'h0);
    chk(at(32'h3DC), 32'hC0C0_0004);
    wb_acc(RD, ca(4'hF, CH_SEMA), 32'h0);
    chk(rd, 32'h0);
  endtask
  // ==================================================
  // verdict and main sequence
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    close_out;
  end
  initial begin
    err_count = 0;
    comparisons = 0;
    rst_i = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 9'h000;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    dma_req_i = '0;
    lat = 4'h0;
    err_addr = 32'hFFFF_FFFF;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs;
    t_chain;
    t_trig;
    wb_acc(WR, REG_IRQ_EN, 32'hFFFF_0000);
    err_addr <= 32'h200;
    t_fault(4'h2, 32'h100, ctl(1'h1, ST_INC, ST_INC, 5'h00, 16'h0001), 32'h3);
    err_addr <= 32'hFFFF_FFFF;
    wb_acc(WR, REG_TMO, 32'h4);
    lat <= 4'hA;
    t_fault(4'h1, 32'h140, ctl(1'h1, ST_INC, ST_INC, 5'h00, 16'h0001), 32'h1);
    lat <= 4'h0;
    wb_acc(WR, REG_TMO, {16'h0, TMO_RST});
    t_fault(4'h0, 32'h180, ctl(1'h1, ST_INC, ST_INC, 5'h1F, 16'h0020), 32'h2);
    t_2d;
    close_out;
  end
endmodule
